// >>> pkg/bitbang_pkg.sv
// Constants and types for one channel's bit-bang data path.
// Assumes a single core clock that stands for the baud reference.
package bitbang_pkg;

    // ------------------------------------------------------------
    // Clock reference
    // ------------------------------------------------------------
    localparam int OSC_HZ = 6000000; // Oscillator input
    localparam int REF_MULT = 8; // Multiplier factor
    localparam int REF_HZ = OSC_HZ * REF_MULT; // 48 MHz baud reference

    // ------------------------------------------------------------
    // Prescaler fields
    // ------------------------------------------------------------
    localparam int DIV_INT_W = 14; // Integer divisor width
    localparam int DIV_FRAC_W = 3; // Fraction width in eighths
    localparam int DIV_CNT_W = 15; // Counter holds up to 16,384
    localparam logic [DIV_CNT_W-1:0] DIV_MIN = 15'h0002; // Smallest n
    localparam logic [DIV_CNT_W-1:0] DIV_MAX = 15'h4000; // n when field is zero

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    localparam int TX_DEPTH = 128; // Transmit buffer bytes
    localparam int TX_PTR_W = 7; // Transmit pointer width
    localparam int RX_DEPTH = 384; // Receive buffer bytes
    localparam int RX_PTR_W = 9; // Receive pointer width
    localparam logic [RX_PTR_W-1:0] RX_LAST = 9'h17f; // Last receive index
    localparam logic [RX_PTR_W:0] RX_FULL = 10'h180; // Receive full count
    localparam logic [RX_PTR_W:0] PKT_SIZE = 10'h040; // Normal packet bytes

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        MODE_OFF = 2'b00, // Port idle, pins released
        MODE_ASYNC = 2'b01, // Timer paced bit-bang
        MODE_SYNC = 2'b10 // Sample only on write
    } mode_t;

    typedef enum logic
    {
        RX_IDLE = 1'b0, // Waiting for host request
        RX_SEND = 1'b1 // Releasing a packet
    } rx_state_t;

    typedef struct packed
    {
        logic [7:0] oe; // Per-line output enable
        logic [7:0] data; // Per-line output level
    } port_drive_t;

endpackage : bitbang_pkg

// >>> core/bitbang_channel.sv
// One channel's bit-bang data path: prescaler, buffers, port, strobes.
// Assumes host side handshakes on the core clock and pins are asynchronous.
`timescale 1ns/10ps
module bitbang_channel
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire bitbang_pkg::mode_t i_mode,
    input wire logic [13:0] i_div_int,
    input wire logic [2:0] i_div_frac,
    input wire logic [7:0] i_dir,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    input wire logic i_rx_req,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    input wire logic [7:0] i_pin,
    output bitbang_pkg::port_drive_t o_port,
    output logic o_wr_strobe_n,
    output logic o_rd_strobe_n,
    output logic o_baud_x16,
    input wire logic i_send_now_wake_n
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [14:0] pre_cnt, next_pre_cnt; // Cycles left in current period
    logic [2:0] frac_acc, next_frac_acc; // Carried eighths
    logic pace; // One-cycle x16 tick
    logic [14:0] div_n; // Effective integer n
    logic [3:0] frac_sum; // Fraction accumulation
    logic [7:0] tx_mem [bitbang_pkg::TX_DEPTH]; // Transmit buffer
    logic [6:0] tx_rd, next_tx_rd, tx_wr, next_tx_wr;
    logic [7:0] tx_cnt, next_tx_cnt; // Bytes held, 0..128
    logic [7:0] rx_mem [bitbang_pkg::RX_DEPTH]; // Receive buffer
    logic [8:0] rx_rd, next_rx_rd, rx_wr, next_rx_wr;
    logic [9:0] rx_cnt, next_rx_cnt; // Bytes held, 0..384
    logic [9:0] burst, next_burst; // Bytes left in packet
    bitbang_pkg::rx_state_t rx_state, next_rx_state;
    bitbang_pkg::port_drive_t next_port;
    logic next_wr_n, next_rd_n;
    logic [7:0] pin_s1, pin_s2, pin_s3, pin_ok, next_pin_ok; // Pin sync
    logic sn_s1, sn_s2, sn_s3, sn_ok, next_sn_ok; // Send-now sync
    logic flush, next_flush; // Send-now pending
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic active; // Any bit-bang mode

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // Zero field means 16,384; values below two clamp to two
    always_comb
    begin
        if (i_div_int == 14'h0000)
            div_n = bitbang_pkg::DIV_MAX;
        else if ({1'b0, i_div_int} < bitbang_pkg::DIV_MIN)
            div_n = bitbang_pkg::DIV_MIN;
        else
            div_n = {1'b0, i_div_int};
        frac_sum = {1'b0, frac_acc} + {1'b0, i_div_frac};
        pace = (pre_cnt == 15'h0000);
        next_pre_cnt = pre_cnt - 15'h0001;
        next_frac_acc = frac_acc;
        if (pace)
        begin
            // Carry out adds one cycle; eighths spread evenly
            next_pre_cnt = div_n - 15'h0001 + {14'h0000, frac_sum[3]};
            next_frac_acc = frac_sum[2:0];
        end
    end
    // Prescaler registers; core clock stands for the 48 MHz reference
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pre_cnt <= 15'h0000;
            frac_acc <= 3'h0;
        end
        else
        begin
            pre_cnt <= next_pre_cnt;
            frac_acc <= next_frac_acc;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Three stages; accept a change once stages two and three agree
    always_comb
    begin
        next_pin_ok = pin_ok;
        for (int i = 0; i < 8; i++)
        begin
            if (pin_s2[i] == pin_s3[i])
                next_pin_ok[i] = pin_s3[i];
        end
        next_sn_ok = (sn_s2 == sn_s3) ? sn_s3 : sn_ok;
    end
    // Synchroniser flops
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
            pin_ok <= 8'h00;
            sn_s1 <= 1'b1;
            sn_s2 <= 1'b1;
            sn_s3 <= 1'b1;
            sn_ok <= 1'b1;
        end
        else
        begin
            pin_s1 <= i_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_ok <= next_pin_ok;
            sn_s1 <= i_send_now_wake_n;
            sn_s2 <= sn_s1;
            sn_s3 <= sn_s2;
            sn_ok <= next_sn_ok;
        end
    end

    // ------------------------------------------------------------
    // Port engine
    // ------------------------------------------------------------
    // Each tick moves at most one buffered byte to the pins and may sample them
    always_comb
    begin
        active = (i_mode == bitbang_pkg::MODE_ASYNC) || (i_mode == bitbang_pkg::MODE_SYNC);
        tx_pop = 1'b0;
        rx_push = 1'b0;
        next_port = o_port;
        next_wr_n = 1'b1;
        next_rd_n = 1'b1;
        next_port.oe = active ? i_dir : 8'h00;
        case (i_mode)
            bitbang_pkg::MODE_ASYNC:
            begin
                // Timer paced write, free running read
                if (pace && tx_cnt != 8'h00)
                begin
                    tx_pop = 1'b1;
                    next_port.data = tx_mem[tx_rd];
                    next_wr_n = 1'b0;
                end
                if (pace && rx_cnt != bitbang_pkg::RX_FULL)
                begin
                    rx_push = 1'b1;
                    next_rd_n = 1'b0;
                end
            end
            bitbang_pkg::MODE_SYNC:
            begin
                // Read only alongside a write, one byte back per byte out
                if (pace && tx_cnt != 8'h00 && rx_cnt != bitbang_pkg::RX_FULL)
                begin
                    tx_pop = 1'b1;
                    rx_push = 1'b1;
                    next_port.data = tx_mem[tx_rd];
                    next_wr_n = 1'b0;
                    next_rd_n = 1'b0;
                end
            end
            default:
            begin
                // Idle: pins released, no strobes
                next_port.oe = 8'h00;
            end
        endcase
    end
    // Port and strobe registers
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_port <= '{oe: 8'h00, data: 8'h00};
            o_wr_strobe_n <= 1'b1;
            o_rd_strobe_n <= 1'b1;
            o_baud_x16 <= 1'b0;
        end
        else
        begin
            o_port <= next_port;
            o_wr_strobe_n <= next_wr_n;
            o_rd_strobe_n <= next_rd_n;
            o_baud_x16 <= pace;
        end
    end

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    // Host fills, port engine drains
    always_comb
    begin
        o_tx_ready = (tx_cnt != 8'(bitbang_pkg::TX_DEPTH));
        tx_push = i_tx_valid && o_tx_ready;
        next_tx_wr = tx_push ? tx_wr + 7'h01 : tx_wr;
        next_tx_rd = tx_pop ? tx_rd + 7'h01 : tx_rd;
        next_tx_cnt = tx_cnt + {7'h00, tx_push} - {7'h00, tx_pop};
    end
    // Transmit pointers and storage
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_wr <= 7'h00;
            tx_rd <= 7'h00;
            tx_cnt <= 8'h00;
        end
        else
        begin
            tx_wr <= next_tx_wr;
            tx_rd <= next_tx_rd;
            tx_cnt <= next_tx_cnt;
            if (tx_push)
                tx_mem[tx_wr] <= i_tx_data;
        end
    end

    // ------------------------------------------------------------
    // Receive buffer and release
    // ------------------------------------------------------------
    // Full packet or pending flush lets a host request start a burst
    always_comb
    begin
        next_rx_state = rx_state;
        next_burst = burst;
        next_flush = flush;
        if (sn_ok && !next_sn_ok)
            next_flush = 1'b1;
        o_rx_valid = (rx_state == bitbang_pkg::RX_SEND) && (burst != 10'h000);
        o_rx_data = rx_mem[rx_rd];
        rx_pop = o_rx_valid && i_rx_ready;
        case (rx_state)
            bitbang_pkg::RX_IDLE:
            begin
                if (i_rx_req && flush)
                begin
                    // Whole buffer regardless of packet size
                    next_burst = rx_cnt;
                    next_flush = sn_ok && !next_sn_ok; // Fresh edge survives
                    next_rx_state = bitbang_pkg::RX_SEND;
                end
                else if (i_rx_req && rx_cnt >= bitbang_pkg::PKT_SIZE)
                begin
                    next_burst = bitbang_pkg::PKT_SIZE;
                    next_rx_state = bitbang_pkg::RX_SEND;
                end
            end
            bitbang_pkg::RX_SEND:
            begin
                if (rx_pop)
                    next_burst = burst - 10'h001;
                if (burst == 10'h000 || (rx_pop && burst == 10'h001))
                    next_rx_state = bitbang_pkg::RX_IDLE;
            end
            default:
            begin
                next_rx_state = bitbang_pkg::RX_IDLE;
            end
        endcase
        next_rx_wr = rx_push ? ((rx_wr == bitbang_pkg::RX_LAST) ? 9'h000 : rx_wr + 9'h001) : rx_wr;
        next_rx_rd = rx_pop ? ((rx_rd == bitbang_pkg::RX_LAST) ? 9'h000 : rx_rd + 9'h001) : rx_rd;
        next_rx_cnt = rx_cnt + {9'h000, rx_push} - {9'h000, rx_pop};
    end
    // Receive pointers, state and storage
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_wr <= 9'h000;
            rx_rd <= 9'h000;
            rx_cnt <= 10'h000;
            burst <= 10'h000;
            flush <= 1'b0;
            rx_state <= bitbang_pkg::RX_IDLE;
        end
        else
        begin
            rx_wr <= next_rx_wr;
            rx_rd <= next_rx_rd;
            rx_cnt <= next_rx_cnt;
            burst <= next_burst;
            flush <= next_flush;
            rx_state <= next_rx_state;
            if (rx_push)
                rx_mem[rx_wr] <= pin_ok;
        end
    end
endmodule : bitbang_channel

// >>> testbench/bitbang_channel_asserts.sv
// Concurrent checks on one bit-bang channel, seen from its ports.
// Assumes one clock domain and a bench that resets between modes.
`timescale 1ns/10ps
module bitbang_channel_chk
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire bitbang_pkg::mode_t i_mode,
    input wire logic [13:0] i_div_int,
    input wire logic [2:0] i_div_frac,
    input wire logic [7:0] i_dir,
    input wire logic i_rx_ready,
    input wire logic o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire bitbang_pkg::port_drive_t o_port,
    input wire logic o_wr_strobe_n,
    input wire logic o_rd_strobe_n,
    input wire logic o_baud_x16
);
    logic [15:0] gap; // Cycles since last baud pulse, 0 before the first
    logic [15:0] next_gap;
    logic [1:0] up; // Cycles since reset, saturating
    logic [1:0] next_up;
    // Next values of the helper counters
    always_comb
    begin
        next_gap = (gap == 16'h0000 || gap == 16'hffff) ? gap : gap + 16'h0001;
        if (o_baud_x16)
            next_gap = 16'h0001;
        next_up = (up == 2'h3) ? up : up + 2'h1;
    end
    // Register the helper counters
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gap <= 16'h0000;
            up <= 2'h0;
        end
        else
        begin
            gap <= next_gap;
            up <= next_up;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rx_stall;
        o_rx_valid && !i_rx_ready;
    endsequence
    sequence s_rx_held;
        o_rx_valid && $stable(o_rx_data);
    endsequence
    chk_baud_gap:
        assert property (o_baud_x16 && gap != 16'h0000 && i_div_int >= 14'h0002
            && i_div_int <= 14'h03e8 |-> gap == {2'h0, i_div_int}
            || (i_div_frac != 3'h0 && gap == {2'h0, i_div_int} + 16'h0001))
        else $error("baud period off");
    chk_baud_single:
        assert property (o_baud_x16 |=> !o_baud_x16) else $error("baud pulse too long");
    chk_wr_single:
        assert property (!o_wr_strobe_n |=> o_wr_strobe_n) else $error("write strobe too long");
    chk_wr_mode:
        assert property (!o_wr_strobe_n |-> $past(i_mode) inside
            {bitbang_pkg::MODE_ASYNC, bitbang_pkg::MODE_SYNC}) else $error("write while off");
    chk_async_pace:
        assert property (!o_wr_strobe_n && $past(i_mode) == bitbang_pkg::MODE_ASYNC
            |-> o_baud_x16) else $error("async write off pace");
    chk_oe_dir:
        assert property (up == 2'h3 && $past(i_mode) == bitbang_pkg::MODE_ASYNC
            && $stable(i_dir) |-> o_port.oe == i_dir) else $error("enables differ");
    chk_port_off:
        assert property (up == 2'h3 && $past(i_mode) == bitbang_pkg::MODE_OFF
            |-> o_port.oe == 8'h00) else $error("pins driven while off");
    chk_sync_pair:
        assert property ($past(i_mode) == bitbang_pkg::MODE_SYNC
            |-> o_rd_strobe_n == o_wr_strobe_n) else $error("sample not paired");
    chk_rx_hold:
        assert property (s_rx_stall |=> s_rx_held) else $error("receive byte dropped");
endmodule : bitbang_channel_chk

bind bitbang_channel bitbang_channel_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_mode(i_mode), .i_div_int(i_div_int), .i_div_frac(i_div_frac), .i_dir(i_dir),
    .i_rx_ready(i_rx_ready), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
    .o_port(o_port), .o_wr_strobe_n(o_wr_strobe_n), .o_rd_strobe_n(o_rd_strobe_n),
    .o_baud_x16(o_baud_x16));

// >>> testbench/pin_partner.sv
// Model of the external logic on the channel's parallel pins.
// Assumes the bench picks the level returned and asks for send-now.
`timescale 1ns/10ps
module pin_partner
(
    input wire logic i_mclk,
    input wire bitbang_pkg::port_drive_t i_port,
    input wire logic [7:0] i_ext,
    input wire logic i_flush,
    output logic [7:0] o_pin,
    output logic o_send_now_wake_n
);
    logic [2:0] low_cnt = 3'h0; // Cycles left in the send-now strobe
    // Each line shows the channel's level where it drives, else ours
    assign o_pin = (i_port.oe & i_port.data) | (~i_port.oe & i_ext);
    // Strobe send-now low for four cycles on request
    always @(posedge i_mclk)
    begin
        if (i_flush)
            low_cnt <= 3'h4;
        else if (low_cnt != 3'h0)
            low_cnt <= low_cnt - 3'h1;
    end
    assign o_send_now_wake_n = (low_cnt == 3'h0);
endmodule : pin_partner

// >>> testbench/tb_top.sv
// Self-checking bench for one bit-bang channel and its pin model.
// Assumes the package is compiled first; one 10 MHz clock.
`timescale 1ns/10ps
module tb_top;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    bitbang_pkg::mode_t i_mode = bitbang_pkg::MODE_OFF;
    logic [13:0] i_div_int = 14'h0002;
    logic [2:0] i_div_frac = 3'h0;
    logic [7:0] i_dir = 8'h00;
    logic i_tx_valid = 1'b0;
    logic [7:0] i_tx_data = 8'h00;
    logic i_rx_req = 1'b0;
    logic i_rx_ready = 1'b0;
    logic [7:0] ext = 8'h00; // Level the pin model returns
    logic flush = 1'b0; // Asks the model for a send-now strobe
    logic o_tx_ready, o_rx_valid, o_wr_strobe_n, o_rd_strobe_n, o_baud_x16, send_n;
    logic [7:0] o_rx_data, pin;
    bitbang_pkg::port_drive_t o_port;
    int errors = 0;
    int checks = 0;
    always #50 i_mclk = ~i_mclk;
    bitbang_channel u_bitbang_channel (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode(i_mode),
        .i_div_int(i_div_int), .i_div_frac(i_div_frac), .i_dir(i_dir),
        .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
        .i_rx_req(i_rx_req), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
        .i_rx_ready(i_rx_ready), .i_pin(pin), .o_port(o_port), .o_wr_strobe_n(o_wr_strobe_n),
        .o_rd_strobe_n(o_rd_strobe_n), .o_baud_x16(o_baud_x16), .i_send_now_wake_n(send_n));
    pin_partner u_pin_partner (.i_mclk(i_mclk), .i_port(o_port), .i_ext(ext),
        .i_flush(flush), .o_pin(pin), .o_send_now_wake_n(send_n));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            errors++;
            $display("[ERR] t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_cnt
    task automatic step();
        @(posedge i_mclk);
        #10;
    endtask : step
    task automatic timeout();
        errors++;
        $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    endtask : timeout
    task automatic rst_dut(input bitbang_pkg::mode_t m, input logic [13:0] n,
        input logic [2:0] f, input logic [7:0] d, input logic [7:0] e);
        i_rst_n = 1'b0;
        i_mode = m;
        i_div_int = n;
        i_div_frac = f;
        i_dir = d;
        ext = e;
        repeat (2) step();
        i_rst_n = 1'b1;
    endtask : rst_dut
    // Cycles until a baud pulse (sel 0) or a write strobe (sel 1)
    task automatic wait_on(input int sel, output int n);
        n = 0;
        for (int k = 0; k < 3000; k++)
        begin
            step();
            n++;
            if ((sel == 0) ? (o_baud_x16 === 1'b1) : (o_wr_strobe_n === 1'b0))
                return;
        end
        timeout();
    endtask : wait_on
    // Offer one byte; valid stays up for back-to-back offers
    task automatic push(input logic [7:0] b);
        i_tx_valid = 1'b1;
        i_tx_data = b;
        for (int k = 0; k < 300; k++)
        begin
            if (o_tx_ready === 1'b1)
            begin
                step();
                return;
            end
            step();
        end
        timeout();
    endtask : push
    // One host request; first byte is stalled a cycle, the rest taken at once
    task automatic read_burst(output int cnt, input logic [7:0] expd);
        i_rx_req = 1'b1;
        step();
        i_rx_req = 1'b0;
        step();
        i_rx_ready = 1'b1;
        cnt = 0;
        for (int k = 0; k < 400; k++)
        begin
            if (o_rx_valid === 1'b1)
            begin
                cnt++;
                cmp_val({8'h00, o_rx_data}, {8'h00, expd});
            end
            else if (k > 2)
                break;
            step();
        end
        i_rx_ready = 1'b0;
    endtask : read_burst
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rst_dut(bitbang_pkg::MODE_OFF, 14'h0002, 3'h0, 8'hff, 8'h00);
        cmp_val(o_port, 16'h0000);
        cmp_val({14'h0000, o_wr_strobe_n, o_rd_strobe_n}, 16'h0003);
        cmp_val({15'h0000, o_tx_ready}, 16'h0001);
    endtask : t_reset
    task automatic t_prescale();
        int n;
        int sum;
        logic [16:0] tab [5] = '{17'h00010, 17'h00014, 17'h0002f, 17'h00008, 17'h00019};
        foreach (tab[i])
        begin
            rst_dut(bitbang_pkg::MODE_ASYNC, tab[i][16:3], tab[i][2:0], 8'h00, 8'h00);
            wait_on(0, n);
            sum = 0;
            repeat (8)
            begin
                wait_on(0, n);
                sum += n;
            end
            cmp_cnt(sum, 8 * ((tab[i][16:3] < 2) ? 2 : tab[i][16:3]) + tab[i][2:0]);
        end
    endtask : t_prescale
    task automatic t_async();
        int n;
        logic [7:0] pat [3] = '{8'h3c, 8'hc3, 8'h5a};
        rst_dut(bitbang_pkg::MODE_ASYNC, 14'h0008, 3'h0, 8'hff, 8'h00);
        foreach (pat[i])
            push(pat[i]);
        i_tx_valid = 1'b0;
        foreach (pat[i])
        begin
            wait_on(1, n);
            cmp_val(o_port, {8'hff, pat[i]});
            if (i > 0)
                cmp_cnt(n, 8);
        end
    endtask : t_async
    task automatic t_sync();
        int wr;
        int rd;
        int cnt;
        rst_dut(bitbang_pkg::MODE_SYNC, 14'h0028, 3'h0, 8'h00, 8'h96);
        for (int i = 0; i < 4; i++)
            push(8'h10 + i[7:0]);
        i_tx_valid = 1'b0;
        wr = 0;
        rd = 0;
        repeat (200)
        begin
            step();
            wr += (o_wr_strobe_n === 1'b0);
            rd += (o_rd_strobe_n === 1'b0);
        end
        cmp_cnt(wr, 4);
        cmp_cnt(rd, 4);
        read_burst(cnt, 8'h96);
        cmp_cnt(cnt, 0);
        flush = 1'b1;
        step();
        flush = 1'b0;
        repeat (10) step();
        read_burst(cnt, 8'h96);
        cmp_cnt(cnt, 4);
    endtask : t_sync
    task automatic t_rx_depth();
        int cnt;
        rst_dut(bitbang_pkg::MODE_OFF, 14'h0002, 3'h0, 8'h00, 8'h3c);
        repeat (10) step();
        i_mode = bitbang_pkg::MODE_ASYNC;
        repeat (900) step();
        i_mode = bitbang_pkg::MODE_OFF;
        step();
        for (int i = 0; i < 7; i++)
        begin
            read_burst(cnt, 8'h3c);
            cmp_cnt(cnt, (i < 6) ? 64 : 0);
        end
    endtask : t_rx_depth
    task automatic t_tx_full();
        int acc;
        rst_dut(bitbang_pkg::MODE_OFF, 14'h0002, 3'h0, 8'h00, 8'h00);
        i_tx_valid = 1'b1;
        acc = 0;
        repeat (140)
        begin
            acc += (o_tx_ready === 1'b1);
            step();
        end
        i_tx_valid = 1'b0;
        cmp_cnt(acc, 128);
        cmp_val({15'h0000, o_tx_ready}, 16'h0000);
    endtask : t_tx_full
    // Main sequence
    initial
    begin
        t_reset();
        t_prescale();
        t_async();
        t_sync();
        t_rx_depth();
        t_tx_full();
        end_sim();
    end
endmodule : tb_top
